// >>> core/link_jabber_pkg.sv
// Contract
// - bit 0 of tenbase_config is jabber_enable_bit, RW, default 1; gates 10 Mb/s jabber in full duplex or loopback only.
// - transceiver_loopback_bit is bit 11 of loopback_bypass_reg at 18h; jabber setting applies.
// - jabber_enable_bit is ignored entirely at 100 Mb/s.
// - 100 Mb/s receive timeout about 722 us without 15 idles forces carrier sense.
// - hysteresis timer counts 500 down to 0, then link advances and timer reloads 500.
// - signal detect drop during hysteresis returns link machine to link-down.
// - link status equals cipher-in-sync: 15 idles received while link test fail is low.
// - link-down latches status low two cycles later; held value refreshed only by a read.
// - link LED follows signal detect energy, independent of the link status bit.
package link_jabber_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] STATUS_ADDR = 5'h01;
    localparam logic [4:0] LOOPBACK_ADDR = 5'h18;
    localparam logic [4:0] TENBASE_ADDR = 5'h1c;
    localparam int unsigned JAB_EN_POS = 0;
    localparam int unsigned LPBK_POS = 11;
    localparam int unsigned LINK_STAT_POS = 2;
    localparam logic [15:0] TENBASE_RESET = 16'h80b9;
    localparam logic [15:0] TENBASE_RW_MASK = 16'h80bd;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned TICK_CYCLES_C = NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned JAB_TIMEOUT_US_C = 722;
    localparam int unsigned LINK_HYST_US_C = 500;
    localparam int unsigned TMR_W = 12;
    localparam logic [3:0] IDLE_NEED = 4'hf;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LINK_DOWN = 3'b001,
        LINK_HYST = 3'b010,
        LINK_UP = 3'b100
    } link_state_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;
endpackage : link_jabber_pkg

// >>> core/tick_down_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tick_down_timer #(
    parameter int unsigned WIDTH = 12,
    parameter logic [WIDTH-1:0] RELOAD = 12'h1f4
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic reload_in,
    input wire logic step_in,
    output logic [WIDTH-1:0] count_out,
    output logic done_out
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // reload has priority so a cut-short interval never resumes mid-way
    always_comb begin
        count_d = count_q;
        if (reload_in) begin
            count_d = RELOAD;
        end else if (step_in && (count_q != '0)) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_q <= RELOAD;
        end else begin
            count_q <= count_d;
        end
    end

    assign count_out = count_q;
    assign done_out = (count_q == '0);
endmodule : tick_down_timer
`default_nettype wire

// >>> core/link_status_jabber_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module link_status_jabber_monitor
    import link_jabber_pkg::*;
#(
    parameter int unsigned LINK_HYST_US = LINK_HYST_US_C,
    parameter int unsigned JAB_TIMEOUT_US = JAB_TIMEOUT_US_C,
    parameter int unsigned TICK_CYC = TICK_CYCLES_C
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic signal_detect_pair_in,
    input wire logic speed_100_in,
    input wire logic full_duplex_in,
    input wire logic symbol_valid_in,
    input wire logic idle_symbol_in,
    input wire mgmt_req_t mgmt_req_in,
    output logic [15:0] mgmt_rdata_out,
    output logic jabber_carrier_force_out,
    output logic jabber_10_active_out,
    output logic link_led_out,
    output logic link_up_out
);
    localparam logic [TMR_W-1:0] HYST_LOAD = TMR_W'(LINK_HYST_US);
    localparam logic [TMR_W-1:0] JAB_LIMIT = TMR_W'(JAB_TIMEOUT_US);
    localparam logic [TMR_W-1:0] TICK_LAST = TMR_W'(TICK_CYC - 1);

    // ----------------------------------------------------------------
    // signal detect synchroniser and microsecond tick
    // ----------------------------------------------------------------
    logic sd_meta_q, sd_sync_q, led_q;
    logic [TMR_W-1:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;

    always_comb begin
        tick_d = (tick_cnt_q == TICK_LAST);
        tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sd_meta_q <= 1'b0;
            sd_sync_q <= 1'b0;
            led_q <= 1'b0;
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            sd_meta_q <= signal_detect_pair_in;
            sd_sync_q <= sd_meta_q;
            led_q <= sd_sync_q;
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0] tenbase_config_q, tenbase_config_d;
    logic lpbk_q, lpbk_d;
    logic [15:0] rdata_q, rdata_d;
    logic stat_latch_q, stat_latch_d;
    logic jab10_q, jab10_d;
    logic cipher_q;
    logic status_rd;

    assign status_rd = mgmt_req_in.rd && (mgmt_req_in.addr == STATUS_ADDR);

    always_comb begin
        tenbase_config_d = tenbase_config_q;
        lpbk_d = lpbk_q;
        if (mgmt_req_in.wr && (mgmt_req_in.addr == TENBASE_ADDR)) begin
            tenbase_config_d = mgmt_req_in.wdata & TENBASE_RW_MASK;
        end
        if (mgmt_req_in.wr && (mgmt_req_in.addr == LOOPBACK_ADDR)) begin
            lpbk_d = mgmt_req_in.wdata[LPBK_POS];
        end
        rdata_d = rdata_q;
        if (mgmt_req_in.rd) begin
            case (mgmt_req_in.addr)
                TENBASE_ADDR: rdata_d = tenbase_config_q;
                LOOPBACK_ADDR: rdata_d = ZERO16 | (16'(lpbk_q) << LPBK_POS);
                STATUS_ADDR: rdata_d = ZERO16 | (16'(stat_latch_q) << LINK_STAT_POS);
                default: rdata_d = ZERO16;
            endcase
        end
        // low latches at once; only a status read refreshes it, so the
        // first read shows the stored fall and the second the live state
        if (status_rd) begin
            stat_latch_d = cipher_q;
        end else begin
            stat_latch_d = stat_latch_q & cipher_q;
        end
        // speed overrides everything: the enable has no meaning at 100 Mb/s
        if (speed_100_in) begin
            jab10_d = 1'b0;
        end else if (full_duplex_in || lpbk_q) begin
            jab10_d = tenbase_config_q[JAB_EN_POS];
        end else begin
            jab10_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tenbase_config_q <= TENBASE_RESET;
            lpbk_q <= 1'b0;
            rdata_q <= ZERO16;
            stat_latch_q <= 1'b0;
            jab10_q <= 1'b1;
        end else begin
            tenbase_config_q <= tenbase_config_d;
            lpbk_q <= lpbk_d;
            rdata_q <= rdata_d;
            stat_latch_q <= stat_latch_d;
            jab10_q <= jab10_d;
        end
    end

    // ----------------------------------------------------------------
    // link monitor with hysteresis timer
    // ----------------------------------------------------------------
    link_state_t state_q, state_d;
    logic tmr_reload, tmr_done;
    logic [TMR_W-1:0] tmr_count;
    logic link_test_fail;

    always_comb begin
        state_d = state_q;
        tmr_reload = 1'b0;
        case (state_q)
            LINK_DOWN: begin
                if (sd_sync_q) begin
                    state_d = LINK_HYST;
                end
            end
            LINK_HYST: begin
                if (!sd_sync_q) begin
                    state_d = LINK_DOWN;
                    tmr_reload = 1'b1;
                end else if (tmr_done) begin
                    state_d = LINK_UP;
                    tmr_reload = 1'b1;
                end
            end
            LINK_UP: begin
                if (!sd_sync_q) begin
                    state_d = LINK_DOWN;
                end
            end
            default: begin
                state_d = LINK_DOWN;
                tmr_reload = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= LINK_DOWN;
        end else begin
            state_q <= state_d;
        end
    end

    tick_down_timer #(
        .WIDTH(TMR_W),
        .RELOAD(HYST_LOAD)
    ) u_hyst_timer (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .reload_in(tmr_reload),
        .step_in(tick_q && (state_q == LINK_HYST)),
        .count_out(tmr_count),
        .done_out(tmr_done)
    );

    assign link_test_fail = (state_q != LINK_UP);

    // ----------------------------------------------------------------
    // idle counting, cipher sync and descrambler jabber
    // ----------------------------------------------------------------
    logic [3:0] idle_cnt_q, idle_cnt_d;
    logic cipher_d, stream_q, stream_d, force_q, force_d;
    logic [TMR_W-1:0] jab_us_q, jab_us_d;
    logic idle_full;

    assign idle_full = (idle_cnt_q == IDLE_NEED);

    always_comb begin
        // idles heard before the link is up must not count toward sync
        idle_cnt_d = idle_cnt_q;
        if (link_test_fail) begin
            idle_cnt_d = '0;
        end else if (symbol_valid_in) begin
            if (!idle_symbol_in) begin
                idle_cnt_d = '0;
            end else if (!idle_full) begin
                idle_cnt_d = idle_cnt_q + 1'b1;
            end
        end
        cipher_d = !link_test_fail && (cipher_q || idle_full);
        stream_d = stream_q;
        if (!speed_100_in || idle_full) begin
            stream_d = 1'b0;
        end else if (symbol_valid_in && !idle_symbol_in) begin
            stream_d = 1'b1;
        end
        jab_us_d = '0;
        if (stream_q) begin
            jab_us_d = (tick_q && (jab_us_q != JAB_LIMIT)) ? jab_us_q + 1'b1 : jab_us_q;
        end
        // timeout holds carrier sense until the idles finally arrive
        force_d = force_q;
        if (!speed_100_in || idle_full) begin
            force_d = 1'b0;
        end else if (stream_q && (jab_us_q == JAB_LIMIT)) begin
            force_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            idle_cnt_q <= '0;
            cipher_q <= 1'b0;
            stream_q <= 1'b0;
            jab_us_q <= '0;
            force_q <= 1'b0;
        end else begin
            idle_cnt_q <= idle_cnt_d;
            cipher_q <= cipher_d;
            stream_q <= stream_d;
            jab_us_q <= jab_us_d;
            force_q <= force_d;
        end
    end

    assign mgmt_rdata_out = rdata_q;
    assign jabber_carrier_force_out = force_q;
    assign jabber_10_active_out = jab10_q;
    assign link_led_out = led_q;
    assign link_up_out = stat_latch_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence hyst_expire_s;
        (state_q == LINK_HYST) && tmr_done && sd_sync_q;
    endsequence
    sequence hyst_drop_s;
        (state_q == LINK_HYST) && !sd_sync_q;
    endsequence

    jab_speed_ignore_a: assert property (speed_100_in |=> !jabber_10_active_out)
        else $error("10 Mb/s jabber active at 100 Mb/s");
    jab_enable_off_a: assert property (
        !speed_100_in && full_duplex_in && !tenbase_config_q[JAB_EN_POS]
        |=> !jabber_10_active_out)
        else $error("jabber not disabled by enable bit");
    jab_loopback_on_a: assert property (
        !speed_100_in && lpbk_q && tenbase_config_q[JAB_EN_POS] |=> jabber_10_active_out)
        else $error("jabber not enabled in loopback");
    jab_timeout_a: assert property (
        speed_100_in && stream_q && (jab_us_q == JAB_LIMIT) && !idle_full
        |=> jabber_carrier_force_out)
        else $error("carrier not forced on timeout");
    hyst_done_a: assert property (hyst_expire_s |=> (state_q == LINK_UP)
        && (tmr_count == HYST_LOAD))
        else $error("hysteresis expiry mishandled");
    hyst_drop_a: assert property (hyst_drop_s |=> (state_q == LINK_DOWN)
        && (tmr_count == HYST_LOAD))
        else $error("signal drop not reloading timer");
    cipher_ltf_a: assert property (link_test_fail |=> !cipher_q)
        else $error("cipher sync while link test fails");
    idle_count_hold_a: assert property (link_test_fail |=> (idle_cnt_q == '0))
        else $error("idles counted while link test fails");
    status_latch_a: assert property (
        !cipher_q ##1 !status_rd [*2] |-> !link_up_out)
        else $error("link status not held low");
    led_follow_a: assert property (sd_sync_q |=> link_led_out ##1 $stable(link_led_out)
        or !sd_sync_q)
        else $error("link LED not following signal detect");
endmodule : link_status_jabber_monitor
`default_nettype wire

// >>> testbench/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
    input wire logic core_clk_in,
    input wire logic energy_in,
    input wire logic data_mode_in,
    output logic signal_detect_pair_out,
    output logic symbol_valid_out,
    output logic idle_symbol_out
);
    // ----------------------------------------------------------------
    // remote partner: one symbol a cycle while energy is on the pair
    // ----------------------------------------------------------------
    initial begin
        signal_detect_pair_out = 1'b0;
        symbol_valid_out = 1'b0;
        idle_symbol_out = 1'b0;
    end
    always @(negedge core_clk_in) begin
        signal_detect_pair_out <= energy_in;
        symbol_valid_out <= energy_in;
        // no energy means the symbol line is meaningless, so it toggles
        idle_symbol_out <= energy_in ? ~data_mode_in : ~idle_symbol_out;
    end
endmodule : link_partner_model
`default_nettype wire

// >>> testbench/link_status_jabber_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
module link_status_jabber_monitor_test;
    import link_jabber_pkg::*;
    logic core_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic energy = 1'b0;
    logic data_mode = 1'b0;
    logic speed_100 = 1'b0;
    logic full_duplex = 1'b0;
    mgmt_req_t req = '0;
    wire logic sd;
    wire logic sv;
    wire logic idl;
    logic [15:0] rdata;
    logic [15:0] rd_v;
    logic force_cs;
    logic jab10;
    logic led;
    logic link_up;
    int error_cnt = 0;
    int samples_checked = 0;
    always #2 core_clk_in = ~core_clk_in;
    // short counts: hysteresis 20 cycles, jabber timeout 40 cycles
    link_status_jabber_monitor #(.LINK_HYST_US(5), .JAB_TIMEOUT_US(10), .TICK_CYC(4)) dut_u (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .signal_detect_pair_in(sd),
        .speed_100_in(speed_100), .full_duplex_in(full_duplex), .symbol_valid_in(sv),
        .idle_symbol_in(idl), .mgmt_req_in(req), .mgmt_rdata_out(rdata),
        .jabber_carrier_force_out(force_cs), .jabber_10_active_out(jab10),
        .link_led_out(led), .link_up_out(link_up));
    link_partner_model partner_u (.core_clk_in(core_clk_in), .energy_in(energy),
        .data_mode_in(data_mode), .signal_detect_pair_out(sd), .symbol_valid_out(sv),
        .idle_symbol_out(idl));
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cyc
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        cyc(1);
        req = '0;
        cyc(1);
    endtask : wr
    // rdata holds until the next read, so sampling one cycle late is safe
    task automatic rd(input logic [4:0] a);
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ZERO16};
        cyc(1);
        req = '0;
        cyc(1);
        rd_v = rdata;
    endtask : rd
    task automatic stat(input logic first, input logic second);
        rd(STATUS_ADDR);
        check({15'h0000, rd_v[LINK_STAT_POS]}, {15'h0000, first});
        rd(STATUS_ADDR);
        check({15'h0000, rd_v[LINK_STAT_POS]}, {15'h0000, second});
    endtask : stat
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (50000) @(posedge core_clk_in);
        error_cnt++;
        close_out();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(8);
        arst_n_in = 1'b1;
        check({12'h000, force_cs, jab10, led, link_up}, 16'h0004);
        rd(TENBASE_ADDR);
        check(rd_v, TENBASE_RESET);
        wr(TENBASE_ADDR, 16'hffff);
        rd(TENBASE_ADDR);
        check(rd_v, TENBASE_RW_MASK);
        rd(5'h05);
        check(rd_v, ZERO16);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            speed_100 = i[3];
            full_duplex = i[2];
            wr(LOOPBACK_ADDR, {4'h0, i[1], 11'h000});
            wr(TENBASE_ADDR, {TENBASE_RESET[15:1], i[0]});
            rd(LOOPBACK_ADDR);
            check(rd_v, {4'h0, i[1], 11'h000});
            cyc(2);
            check({15'h0000, jab10},
                {15'h0000, i[3] ? 1'b0 : ((i[2] | i[1]) ? i[0] : 1'b1)});
        end
        wr(LOOPBACK_ADDR, ZERO16);
        full_duplex = 1'b0;
        speed_100 = 1'b1;
        $display("test jabber enable done");
        energy <= 1'b1;
        cyc(2);
        check({15'h0000, led}, 16'h0000);
        cyc(3);
        check({14'h0000, led, link_up}, 16'h0002);
        // drop energy part way through hysteresis, then bring it back
        cyc(10);
        energy <= 1'b0;
        cyc(5);
        energy <= 1'b1;
        cyc(28);
        stat(1'b0, 1'b0);
        cyc(40);
        stat(1'b0, 1'b1);
        check({15'h0000, link_up}, 16'h0001);
        $display("test link hysteresis done");
        energy <= 1'b0;
        cyc(6);
        check({14'h0000, led, link_up}, 16'h0000);
        energy <= 1'b1;
        cyc(70);
        check({14'h0000, led, link_up}, 16'h0002);
        stat(1'b0, 1'b1);
        $display("test latched status done");
        data_mode <= 1'b1;
        cyc(25);
        data_mode <= 1'b0;
        cyc(20);
        check({15'h0000, force_cs}, 16'h0000);
        data_mode <= 1'b1;
        cyc(30);
        check({15'h0000, force_cs}, 16'h0000);
        cyc(25);
        check({15'h0000, force_cs}, 16'h0001);
        data_mode <= 1'b0;
        cyc(25);
        check({15'h0000, force_cs}, 16'h0000);
        $display("test jabber timeout done");
        close_out();
    end
endmodule : link_status_jabber_monitor_test
`default_nettype wire
